// file: mcsr_pkg.sv
// package: offsets, field positions and reset values of the control/status register bank
package mcsr_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] MCSR_OFF_PWR = 8'h08;
  localparam logic [7:0] MCSR_OFF_WAKE = 8'h09;
  localparam logic [7:0] MCSR_OFF_PCHB = 8'h0A;
  localparam logic [7:0] MCSR_OFF_PDN = 8'h0B;
  localparam logic [7:0] MCSR_OFF_PUB = 8'h0C;
  localparam logic [7:0] MCSR_OFF_PUC = 8'h0D;
  localparam logic [7:0] MCSR_OFF_IMASK = 8'h0E;
  localparam logic [7:0] MCSR_OFF_IFLAG = 8'h0F;
  localparam logic [7:0] MCSR_OFF_ACCUM = 8'h10;
  localparam logic [7:0] MCSR_OFF_OPT = 8'h11;
  localparam logic [7:0] MCSR_OFF_DIRB = 8'h12;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MCSR_PWR_WAKEC = 0;
  localparam int MCSR_PWR_ODC = 1;
  localparam int MCSR_PWR_ROPT = 4;
  localparam int MCSR_PWR_LVD = 5;
  localparam int MCSR_PWR_PINSEL = 6;
  localparam int MCSR_PWR_WDT = 7;
  localparam int MCSR_IRQ_TMR = 0;
  localparam int MCSR_IRQ_EXT0 = 2;
  localparam int MCSR_IRQ_EXT1 = 3;
  localparam int MCSR_IRQ_GLOBAL = 7;
  localparam int MCSR_OPT_EDGE = 6;
  // ****************************************************************
  // writable masks and reset values
  // ****************************************************************
  localparam logic [7:0] MCSR_PWR_MASK = 8'hF3;
  localparam logic [7:0] MCSR_PCHB_MASK = 8'h0F;
  localparam logic [7:0] MCSR_IMASK_MASK = 8'h8D;
  localparam logic [7:0] MCSR_IFLAG_MASK = 8'h0D;
  localparam logic [7:0] MCSR_RST_PWR = 8'h81;
  localparam logic [7:0] MCSR_RST_ONES = 8'hFF;
  localparam logic [7:0] MCSR_RST_ZERO = 8'h00;
  localparam logic [7:0] MCSR_RST_OPT = 8'hBF;
endpackage

// file: mcsr_edge.sv
// module: synchronous edge detector for one pin with selectable edge
`timescale 1ns/100ps
module mcsr_edge
  import mcsr_pkg::*;
(
  // clocking
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // pin and control
  input wire logic pin_i,
  input wire logic rise_i,
  // result
  output logic edge_o
);
  logic prev_q;

  // remember last level; reset high so a high pin at start is no edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_q <= 1'b1;
    end else if (en_i) begin
      prev_q <= pin_i;
    end
  end

  // rise_i picks rising, otherwise falling
  always_comb begin
    if (rise_i) begin
      edge_o = en_i & pin_i & ~prev_q;
    end else begin
      edge_o = en_i & ~pin_i & prev_q;
    end
  end
endmodule // mcsr_edge

// file: mcsr_pin_ctl.sv
// module: per-pin weak pull gating against output direction
`timescale 1ns/100ps
module mcsr_pin_ctl
  import mcsr_pkg::*;
(
  // settings, all active low enables
  input wire logic [7:0] pull_dis_i,
  // direction, 1 = input
  input wire logic [7:0] dir_in_i,
  // resulting active-high pull enables
  output logic [7:0] pull_on_o
);
  // pulls only act on input pins
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign pull_on_o[g] = ~pull_dis_i[g] & dir_in_i[g];
    end
  endgenerate
endmodule // mcsr_pin_ctl

// file: mcsr_regs.sv
// module: control/status register bank with interrupt flags and pin controls
//
// Notes on behaviour
// - power bit 0 low enables port C wake
// - power bit 1 makes C6/C7 open-drain
// - power bit 4 enables resistor-option sensing
// - power bit 5 enables low-voltage detector
// - pin-select 0: B0 plain I/O, irq masked
// - pin-select 1: B0 is ext irq0
// - power bit 7 enables watchdog
// - wake register bits low enable B wake
// - page buffer holds four low bits
// - page buffer bits 3:2 select page
// - pull-down register active low, A0-3/B0-3
// - port B pull-high active low
// - port C pull-high active low
// - mask bits 0,2,3 enable sources
// - mask bit 7 is global enable
// - taken interrupt clears global enable
// - return from interrupt sets global enable
// - timer flag set by overflow, sticky
// - ext0 flag on selected edge, sticky
// - ext1 flag on falling edge, sticky
// - unused bits read zero
// - edge select 1 rising, 0 falling
// - pulls off on output pins
// - B0 wake off when ext irq
`timescale 1ns/100ps
module mcsr_regs
  import mcsr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // core events
  input wire logic timer_ovf_i,
  input wire logic ret_irq_i,
  // pins
  input wire logic ext_irq1_pin_i,
  input wire logic [7:0] portb_pins_i,
  input wire logic [7:0] portc_pins_i,
  input wire logic [7:0] porta_dir_i,
  input wire logic [7:0] portc_dir_i,
  // control outputs
  output logic irq_o,
  output logic watchdog_enable_o,
  output logic low_voltage_detect_enable_o,
  output logic resistor_option_enable_o,
  output logic portc_hi_open_drain_o,
  output logic ext_irq_pin_select_o,
  output logic [1:0] page_o,
  output logic [3:0] pc_high_o,
  output logic [7:0] portb_wake_en_o,
  output logic [1:0] portc_wake_en_o,
  output logic [7:0] pulldown_on_o,
  output logic [7:0] portb_pullup_on_o,
  output logic [7:0] portc_pullup_on_o,
  output logic [1:0] portc_ropt_bits_o,
  output logic [7:0] portb_read_o
);
  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] power_control_q;
  logic [7:0] portb_wakeup_control_q;
  logic [7:0] pc_high_buffer_q;
  logic [7:0] pulldown_control_q;
  logic [7:0] portb_pullup_control_q;
  logic [7:0] portc_pullup_control_q;
  logic [7:0] interrupt_mask_q;
  logic [7:0] interrupt_flags_q;
  logic [7:0] accumulator_q;
  logic [7:0] option_q;
  logic [7:0] portb_dir_q;
  logic [7:0] flags_d;
  logic [7:0] rdata_d;
  logic ext0_edge;
  logic ext1_edge;
  logic ext0_pin;
  logic take_irq;
  logic [7:0] pd_on;
  logic [7:0] pub_on;
  logic [7:0] puc_on;
  logic [7:0] pd_dir;
  logic wr_any;

  assign wr_any = clk_en_i & wr_i;

  // ****************************************************************
  // plain configuration registers
  // ****************************************************************
  // unused bits are masked at the write so they always read zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      power_control_q <= MCSR_RST_PWR;
      portb_wakeup_control_q <= MCSR_RST_ONES;
      pc_high_buffer_q <= MCSR_RST_ZERO;
      pulldown_control_q <= MCSR_RST_ONES;
      portb_pullup_control_q <= MCSR_RST_ONES;
      portc_pullup_control_q <= MCSR_RST_ONES;
      accumulator_q <= MCSR_RST_ZERO;
      option_q <= MCSR_RST_OPT;
      portb_dir_q <= MCSR_RST_ONES;
    end else if (wr_any) begin
      case (addr_i)
        MCSR_OFF_PWR: power_control_q <= wdata_i & MCSR_PWR_MASK;
        MCSR_OFF_WAKE: portb_wakeup_control_q <= wdata_i;
        MCSR_OFF_PCHB: pc_high_buffer_q <= wdata_i & MCSR_PCHB_MASK;
        MCSR_OFF_PDN: pulldown_control_q <= wdata_i;
        MCSR_OFF_PUB: portb_pullup_control_q <= wdata_i;
        MCSR_OFF_PUC: portc_pullup_control_q <= wdata_i;
        MCSR_OFF_ACCUM: accumulator_q <= wdata_i;
        MCSR_OFF_OPT: option_q <= wdata_i;
        MCSR_OFF_DIRB: portb_dir_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // interrupt sources
  // ****************************************************************
  // ext0 only sees the pin when selected, otherwise held idle high
  assign ext0_pin = power_control_q[MCSR_PWR_PINSEL] ? portb_pins_i[0] : 1'b1;

  mcsr_edge u_edge0 (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(clk_en_i),
    .pin_i(ext0_pin),
    .rise_i(option_q[MCSR_OPT_EDGE]),
    .edge_o(ext0_edge)
  );

  mcsr_edge u_edge1 (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(clk_en_i),
    .pin_i(ext_irq1_pin_i),
    .rise_i(1'b0),
    .edge_o(ext1_edge)
  );

  // software write first, then hardware sets so a set wins the clear
  always_comb begin
    flags_d = interrupt_flags_q;
    if (wr_any && addr_i == MCSR_OFF_IFLAG) begin
      flags_d = wdata_i & MCSR_IFLAG_MASK;
    end
    if (timer_ovf_i) begin
      flags_d[MCSR_IRQ_TMR] = 1'b1;
    end
    if (ext0_edge && power_control_q[MCSR_PWR_PINSEL]) begin
      flags_d[MCSR_IRQ_EXT0] = 1'b1;
    end
    if (ext1_edge) begin
      flags_d[MCSR_IRQ_EXT1] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      interrupt_flags_q <= MCSR_RST_ZERO;
    end else if (clk_en_i) begin
      interrupt_flags_q <= flags_d;
    end
  end

  // a request is an enabled flag under the global enable
  assign take_irq = interrupt_mask_q[MCSR_IRQ_GLOBAL] &
    (|(interrupt_flags_q & interrupt_mask_q & MCSR_IFLAG_MASK));

  // ****************************************************************
  // interrupt mask and global enable handshake
  // ****************************************************************
  // hardware clear beats a software write in the same cycle, so a
  // taken interrupt can never be re-armed by a racing store
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      interrupt_mask_q <= MCSR_RST_ZERO;
    end else if (clk_en_i) begin
      if (wr_i && addr_i == MCSR_OFF_IMASK) begin
        interrupt_mask_q <= wdata_i & MCSR_IMASK_MASK;
      end
      if (ret_irq_i) begin
        interrupt_mask_q[MCSR_IRQ_GLOBAL] <= 1'b1;
      end
      if (take_irq) begin
        interrupt_mask_q[MCSR_IRQ_GLOBAL] <= 1'b0;
      end
    end
  end

  // request pulse registered so the output comes from a flop
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= take_irq;
    end
  end

  // ****************************************************************
  // pull gating
  // ****************************************************************
  // pull-down register covers A0-3 in low nibble, B0-3 in high nibble
  assign pd_dir = {portb_dir_q[3:0], porta_dir_i[3:0]};

  mcsr_pin_ctl u_pd (
    .pull_dis_i(pulldown_control_q),
    .dir_in_i(pd_dir),
    .pull_on_o(pd_on)
  );

  mcsr_pin_ctl u_pub (
    .pull_dis_i(portb_pullup_control_q),
    .dir_in_i(portb_dir_q),
    .pull_on_o(pub_on)
  );

  mcsr_pin_ctl u_puc (
    .pull_dis_i(portc_pullup_control_q),
    .dir_in_i(portc_dir_i),
    .pull_on_o(puc_on)
  );

  // ****************************************************************
  // control outputs
  // ****************************************************************
  // all outputs registered; one cycle behind the register they mirror
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      watchdog_enable_o <= 1'b0;
      low_voltage_detect_enable_o <= 1'b0;
      resistor_option_enable_o <= 1'b0;
      portc_hi_open_drain_o <= 1'b0;
      ext_irq_pin_select_o <= 1'b0;
      page_o <= 2'h0;
      pc_high_o <= 4'h0;
      portb_wake_en_o <= 8'h00;
      portc_wake_en_o <= 2'h0;
      pulldown_on_o <= 8'h00;
      portb_pullup_on_o <= 8'h00;
      portc_pullup_on_o <= 8'h00;
      portc_ropt_bits_o <= 2'h3;
      portb_read_o <= 8'h00;
    end else if (clk_en_i) begin
      watchdog_enable_o <= power_control_q[MCSR_PWR_WDT];
      low_voltage_detect_enable_o <= power_control_q[MCSR_PWR_LVD];
      resistor_option_enable_o <= power_control_q[MCSR_PWR_ROPT];
      portc_hi_open_drain_o <= power_control_q[MCSR_PWR_ODC];
      ext_irq_pin_select_o <= power_control_q[MCSR_PWR_PINSEL];
      page_o <= pc_high_buffer_q[3:2];
      pc_high_o <= pc_high_buffer_q[3:0];
      portb_wake_en_o <= ~portb_wakeup_control_q &
        {7'h7F, ~power_control_q[MCSR_PWR_PINSEL]};
      portc_wake_en_o <= {2{~power_control_q[MCSR_PWR_WAKEC]}};
      pulldown_on_o <= pd_on;
      portb_pullup_on_o <= pub_on;
      portc_pullup_on_o <= puc_on;
      // sensed resistor pulls the pin low: 0 present, 1 absent
      portc_ropt_bits_o <= power_control_q[MCSR_PWR_ROPT] ?
        portc_pins_i[1:0] : 2'h3;
      // port B reads the pin level even when B0 is the irq pin
      portb_read_o <= portb_pins_i;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // unmapped addresses read zero; data valid the cycle after the strobe
  always_comb begin
    case (addr_i)
      MCSR_OFF_PWR: rdata_d = power_control_q;
      MCSR_OFF_WAKE: rdata_d = portb_wakeup_control_q;
      MCSR_OFF_PCHB: rdata_d = pc_high_buffer_q;
      MCSR_OFF_PDN: rdata_d = pulldown_control_q;
      MCSR_OFF_PUB: rdata_d = portb_pullup_control_q;
      MCSR_OFF_PUC: rdata_d = portc_pullup_control_q;
      MCSR_OFF_IMASK: rdata_d = interrupt_mask_q;
      MCSR_OFF_IFLAG: rdata_d = interrupt_flags_q;
      MCSR_OFF_ACCUM: rdata_d = accumulator_q;
      MCSR_OFF_DIRB: rdata_d = portb_dir_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      rdata_o <= rd_i ? rdata_d : 8'h00;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  unused_zero_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (power_control_q[3:2] == 2'h0) && (interrupt_mask_q[6:4] == 3'h0) &&
    (interrupt_flags_q[7:4] == 4'h0) && !interrupt_flags_q[1])
    else $error("unused register bit set");

  global_clear_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && take_irq) |=> !interrupt_mask_q[MCSR_IRQ_GLOBAL])
    else $error("global enable not cleared on taken interrupt");

  global_return_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && ret_irq_i && !take_irq) |=> interrupt_mask_q[MCSR_IRQ_GLOBAL])
    else $error("return did not set global enable");

  timer_flag_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && timer_ovf_i) |=> interrupt_flags_q[MCSR_IRQ_TMR])
    else $error("timer flag not set");

  ext1_flag_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && ext1_edge) |=> interrupt_flags_q[MCSR_IRQ_EXT1])
    else $error("ext1 flag not set");

  ext0_mask_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && !power_control_q[MCSR_PWR_PINSEL] && !interrupt_flags_q[MCSR_IRQ_EXT0]
     && !(wr_i && addr_i == MCSR_OFF_IFLAG)) |=> !interrupt_flags_q[MCSR_IRQ_EXT0])
    else $error("ext0 flag set while pin not selected");

  // a frozen cycle holds the request, so only look after a live edge
  irq_out_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (irq_o && $past(clk_en_i)) |-> $past(interrupt_mask_q[MCSR_IRQ_GLOBAL]))
    else $error("request without global enable");

  b0_wake_a: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && power_control_q[MCSR_PWR_PINSEL]) |=> !portb_wake_en_o[0])
    else $error("b0 wake enabled while irq pin");
endmodule // mcsr_regs

// file: mcsr_pin_model.sv
// model of the pins and interrupt sources around the register bank
`timescale 1ns/100ps
module mcsr_pin_model (
  // clock
  input wire logic clk_i,
  // event and pin levels
  output logic timer_ovf_o,
  output logic ext1_o,
  output logic [7:0] pb_o,
  output logic [7:0] pc_o,
  // directions, 1 = input
  output logic [7:0] pa_dir_o,
  output logic [7:0] pc_dir_o
);
  // ****************************************************************
  // pin drivers
  // ****************************************************************
  // pins idle high as if pulled up, so reset sees no edge
  initial begin
    timer_ovf_o = 1'b0;
    ext1_o = 1'b1;
    pb_o = 8'hFF;
    pc_o = 8'hFF;
    pa_dir_o = 8'hFF;
    pc_dir_o = 8'hFF;
  end
  // one-cycle overflow pulse, as the timer gives it
  task pulse_timer;
    @(posedge clk_i);
    timer_ovf_o <= 1'b1;
    @(posedge clk_i);
    timer_ovf_o <= 1'b0;
  endtask
  // new pin levels; a resistor to ground on a sensing pin reads low
  task set_pins(input logic [7:0] b, input logic [7:0] c, input logic e1);
    @(posedge clk_i);
    pb_o <= b;
    pc_o <= c;
    ext1_o <= e1;
  endtask
  // direction settings of ports A and C
  task set_dir(input logic [7:0] a, input logic [7:0] c);
    @(posedge clk_i);
    pa_dir_o <= a;
    pc_dir_o <= c;
  endtask
endmodule // mcsr_pin_model

// file: test_mcsr_regs.sv
// testbench: register access, pin controls and interrupt flags
`timescale 1ns/100ps
module test_mcsr_regs import mcsr_pkg::*;;
  logic clk, rst_b, wr, rd, ret, tovf, ext1, irq, wdt, lvd, ropt, odc, pin_sel, cen;
  logic [7:0] addr, wdata, rdata, pb, pc, pa_dir, pc_dir, pb_wake, pdn, pbu, pcu, pb_rd;
  logic [1:0] page, pc_wake, ropt_bits;
  logic [3:0] pch;
  int n_mismatch, n_tests, n_irq, irq_base, cycles;
  logic [7:0] offs [9] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};
  logic [7:0] rstv [9] = '{8'h81, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [7:0] rdbk [9] = '{8'hF3, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h8D, 8'h00, 8'hFF};
  logic [7:0] pwrv [4] = '{8'hF3, 8'h00, 8'h40, 8'h81};
  // ****************************************************************
  // design, partner and clock
  // ****************************************************************
  mcsr_regs mcsr_regs_i (.clk_i(clk), .rst_b_i(rst_b), .clk_en_i(cen), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_ovf_i(tovf),
    .ret_irq_i(ret), .ext_irq1_pin_i(ext1), .portb_pins_i(pb), .portc_pins_i(pc),
    .porta_dir_i(pa_dir), .portc_dir_i(pc_dir), .irq_o(irq), .watchdog_enable_o(wdt),
    .low_voltage_detect_enable_o(lvd), .resistor_option_enable_o(ropt),
    .portc_hi_open_drain_o(odc), .ext_irq_pin_select_o(pin_sel), .page_o(page), .pc_high_o(pch),
    .portb_wake_en_o(pb_wake), .portc_wake_en_o(pc_wake), .pulldown_on_o(pdn),
    .portb_pullup_on_o(pbu), .portc_pullup_on_o(pcu), .portc_ropt_bits_o(ropt_bits),
    .portb_read_o(pb_rd));
  mcsr_pin_model mcsr_pin_model_i (.clk_i(clk), .timer_ovf_o(tovf), .ext1_o(ext1),
    .pb_o(pb), .pc_o(pc), .pa_dir_o(pa_dir), .pc_dir_o(pc_dir));
  // 20 MHz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counts request cycles on the falling edge, where the request is settled,
  // and cuts a hang short
  always @(negedge clk) begin
    cycles++;
    if (irq === 1'b1) n_irq++;
    if (cycles == 6000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // request cycles seen since the last call
  task chk_irq(input int e);
    n_tests++;
    if (n_irq - irq_base != e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, n_irq - irq_base, e);
    end
    irq_base = n_irq;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(rdata, e);
  endtask
  // outputs lag registers and pins by one cycle, edge detectors a little more
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task ret_pulse;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask
  // port B pin 0 moves from one level to another; flags cleared in between
  task ext0_case(input logic sel, input logic [7:0] opt, input logic b1, input logic b2,
                 input logic [7:0] e);
    wr_reg(MCSR_OFF_PWR, {1'b0, sel, 6'h00});
    wr_reg(MCSR_OFF_OPT, opt);
    mcsr_pin_model_i.set_pins({7'h7F, b1}, 8'hFF, 1'b1);
    settle();
    wr_reg(MCSR_OFF_IFLAG, 8'h00);
    mcsr_pin_model_i.set_pins({7'h7F, b2}, 8'hFF, 1'b1);
    settle();
    rd_chk(MCSR_OFF_IFLAG, e);
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst_b, wr, rd, ret, addr, wdata} = '0;
    cen = 1'b1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(offs[i], rstv[i]);
    rd_chk(8'h20, 8'h00);
    // every writable bit set, flag register written zero; unused bits must read back as zero
    for (int i = 0; i < 9; i++) begin
      wr_reg(offs[i], (i == 7) ? 8'h00 : 8'hFF);
      rd_chk(offs[i], rdbk[i]);
    end
    wr_reg(8'h20, 8'h5A);
    rd_chk(8'h20, 8'h00);
    // power bits against their outputs, wake register fully enabled
    wr_reg(MCSR_OFF_WAKE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr_reg(MCSR_OFF_PWR, pwrv[i]);
      settle();
      chk8({3'h0, wdt, lvd, ropt, odc, pin_sel},
        {3'h0, pwrv[i][7], pwrv[i][5:4], pwrv[i][1], pwrv[i][6]});
      chk8({6'h00, pc_wake}, {6'h00, {2{~pwrv[i][0]}}});
      chk8(pb_wake, {7'h7F, ~pwrv[i][6]});
    end
    for (int p = 0; p < 4; p++) begin
      wr_reg(MCSR_OFF_PCHB, {4'hF, p[1:0], 2'b10});
      settle();
      chk8({6'h00, page}, p[7:0]);
      chk8({4'h0, pch}, {4'h0, p[1:0], 2'b10});
    end
    // pulls follow direction: only input pins keep an enabled pull
    mcsr_pin_model_i.set_dir(8'h05, 8'h3C);
    wr_reg(MCSR_OFF_DIRB, 8'h0F);
    wr_reg(MCSR_OFF_PDN, 8'h5A);
    wr_reg(MCSR_OFF_PUB, 8'h33);
    wr_reg(MCSR_OFF_PUC, 8'hC3);
    settle();
    chk8(pdn, {~4'h5 & 4'hF, ~4'hA & 4'h5});
    chk8(pbu, ~8'h33 & 8'h0F);
    chk8(pcu, ~8'hC3 & 8'h3C);
    // resistor present on sensing pin 0 only
    wr_reg(MCSR_OFF_PWR, 8'h50);
    mcsr_pin_model_i.set_pins(8'hA5, 8'hFE, 1'b1);
    settle();
    chk8({6'h00, ropt_bits}, 8'h02);
    chk8(pb_rd, 8'hA5);
    wr_reg(MCSR_OFF_PWR, 8'h00);
    settle();
    chk8({6'h00, ropt_bits}, 8'h03);
    // timer flag with the global enable off: flag only, no request
    mcsr_pin_model_i.set_pins(8'hFF, 8'hFF, 1'b1);
    wr_reg(MCSR_OFF_IFLAG, 8'h00);
    settle();
    wr_reg(MCSR_OFF_IMASK, 8'h0D);
    irq_base = n_irq;
    mcsr_pin_model_i.pulse_timer();
    settle();
    rd_chk(MCSR_OFF_IFLAG, 8'h01);
    chk_irq(0);
    wr_reg(MCSR_OFF_IMASK, 8'h8D);
    settle();
    chk_irq(1);
    rd_chk(MCSR_OFF_IMASK, 8'h0D);
    rd_chk(MCSR_OFF_IFLAG, 8'h01);
    wr_reg(MCSR_OFF_IFLAG, 8'h00);
    ret_pulse();
    settle();
    rd_chk(MCSR_OFF_IMASK, 8'h8D);
    chk_irq(0);
    // external source 1 on its falling edge only
    mcsr_pin_model_i.set_pins(8'hFF, 8'hFF, 1'b0);
    settle();
    rd_chk(MCSR_OFF_IFLAG, 8'h08);
    chk_irq(1);
    wr_reg(MCSR_OFF_IFLAG, 8'h00);
    mcsr_pin_model_i.set_pins(8'hFF, 8'hFF, 1'b1);
    settle();
    rd_chk(MCSR_OFF_IFLAG, 8'h00);
    // external source 0; pin made an input before it is selected
    wr_reg(MCSR_OFF_IMASK, 8'h0D);
    wr_reg(MCSR_OFF_DIRB, 8'hFF);
    ext0_case(1'b0, 8'hFF, 1'b0, 1'b1, 8'h00);
    ext0_case(1'b1, 8'hFF, 1'b1, 1'b0, 8'h00);
    ext0_case(1'b1, 8'hFF, 1'b0, 1'b1, 8'h04);
    ext0_case(1'b1, 8'hBF, 1'b0, 1'b1, 8'h00);
    ext0_case(1'b1, 8'hBF, 1'b1, 1'b0, 8'h04);
    // clock enable low: a write must not land, the accumulator keeps FF
    @(posedge clk);
    cen <= 1'b0;
    wr_reg(8'h10, 8'h55);
    cen <= 1'b1;
    rd_chk(8'h10, 8'hFF);
    test_done();
  end
endmodule // test_mcsr_regs
